// ===== include/tws_pkg.sv
// Package for the two-wire slave receive/transmit control block.
// Holds register offsets, control bit positions, reset values and status codes.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package tws_pkg;

  // Register byte offsets
  localparam logic [4:0] TWS_OFS_CTRL = 5'h00;   // serial_control
  localparam logic [4:0] TWS_OFS_ADDR = 5'h04;   // own_slave_address
  localparam logic [4:0] TWS_OFS_DATA = 5'h08;   // serial_data_reg
  localparam logic [4:0] TWS_OFS_STAT = 5'h0C;   // serial_status

  // Control bit positions
  localparam int TWS_B_FLAG = 7;                 // interrupt_flag, write one to clear
  localparam int TWS_B_AA   = 6;                 // address_acknowledge
  localparam int TWS_B_STA  = 5;                 // start_request
  localparam int TWS_B_STO  = 4;                 // stop_request
  localparam int TWS_B_WC   = 3;                 // write_collision
  localparam int TWS_B_EN   = 2;                 // interface_enable
  localparam int TWS_B_IE   = 0;                 // interrupt_enable

  // Reset values
  localparam logic [7:0] TWS_RST_ADDR = 8'h00;
  localparam logic [7:0] TWS_RST_DATA = 8'hFF;

  // Address compare values
  localparam logic [6:0] TWS_GC_ADDR  = 7'h00;   // general call address

  // Status codes, prescaler bits read as zero
  localparam logic [7:0] TWS_ST_SR_ADR  = 8'h60;
  localparam logic [7:0] TWS_ST_SR_ARB  = 8'h68;
  localparam logic [7:0] TWS_ST_GC_ADR  = 8'h70;
  localparam logic [7:0] TWS_ST_GC_ARB  = 8'h78;
  localparam logic [7:0] TWS_ST_SR_ACK  = 8'h80;
  localparam logic [7:0] TWS_ST_SR_NACK = 8'h88;
  localparam logic [7:0] TWS_ST_GC_ACK  = 8'h90;
  localparam logic [7:0] TWS_ST_GC_NACK = 8'h98;
  localparam logic [7:0] TWS_ST_STOP    = 8'hA0;
  localparam logic [7:0] TWS_ST_ST_ADR  = 8'hA8;
  localparam logic [7:0] TWS_ST_ST_ARB  = 8'hB0;
  localparam logic [7:0] TWS_ST_ST_ACK  = 8'hB8;
  localparam logic [7:0] TWS_ST_ST_NACK = 8'hC0;
  localparam logic [7:0] TWS_ST_ST_LAST = 8'hC8;
  localparam logic [7:0] TWS_ST_NOINFO  = 8'hF8;

  // Bits per serial byte
  localparam logic [3:0] TWS_BITS = 4'h8;

  // Slave engine states
  typedef enum logic [2:0] {
    TWS_IDLE     = 3'b000,
    TWS_ADDR     = 3'b001,
    TWS_ADDR_ACK = 3'b010,
    TWS_HOLD     = 3'b011,
    TWS_RX       = 3'b100,
    TWS_RX_ACK   = 3'b101,
    TWS_TX       = 3'b110,
    TWS_TX_ACK   = 3'b111
  } tws_state_t;

endpackage

// ===== logic/tws_sync.sv
// Two-flop synchroniser for pins that arrive from outside the clock domain.
// Assumes idle-high open-drain lines, so the flops reset to one.
`timescale 1ns/1ns
module tws_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;  // First stage, read only by the second stage

  // Two stages, synchronous reset to the idle line level
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      meta   <= '1;
      o_sync <= '1;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// ===== logic/tws_slave.sv
// Slave receive/transmit control of a two-wire serial interface with an Avalon-MM register port.
// Assumes SCL/SDA arrive asynchronously, an outside master engine reports lost arbitration,
// and the power controller flags deep sleep; the pins are open drain (oe high pulls low).
// Function
// - General-call data acked; next ack follows acknowledge bit
// - General-call data nacked; flag clear returns unaddressed
// - Start request pending: send START when bus free
// - STOP/restart while addressed as receiver: report, return unaddressed
// - Acknowledge bit gates own and general-call recognition
// - Upper seven address bits compared; bit zero enables general call
// - Direction bit one selects transmit, else receive
// - Address and direction received: flag set, valid status
// - Lost arbitration then read address: transmit, report it
// - Acknowledge cleared: last byte, then ACK/NACK state
// - After last byte ignore master; it reads ones
// - Acknowledge zero isolates; recognition resumes when set
// - In deep sleep still match address and wake
// - After wake hold SCL low until flag cleared
// - Data register need not hold last bus byte
// - Read address acked: report, send loaded byte
// - Byte sent and acked: report, send next byte
// - Status reads no-information code while flag clear
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
module tws_slave
  import tws_pkg::*;
(
  input  wire logic        i_mclk,          // System clock, 100 MHz
  input  wire logic        i_rst_n,         // Synchronous reset, active low
  input  wire logic [4:0]  i_address,       // Avalon byte address
  input  wire logic        i_read,          // Avalon read
  input  wire logic        i_write,         // Avalon write
  input  wire logic [31:0] i_writedata,     // Avalon write data
  input  wire logic [3:0]  i_byteenable,    // Avalon byte enables
  output logic      [31:0] o_readdata,      // Avalon read data
  output logic             o_waitrequest,   // Avalon wait request
  input  wire logic        i_scl_in,        // SCL pin level
  output logic             o_scl_out,       // SCL drive value, always low
  output logic             o_scl_oe,        // SCL pull low
  input  wire logic        i_sda_in,        // SDA pin level
  output logic             o_sda_out,       // SDA drive value, always low
  output logic             o_sda_oe,        // SDA pull low
  input  wire logic        i_arb_lost,      // Master engine lost arbitration this frame
  input  wire logic        i_deep_sleep,    // Non-idle sleep mode active
  output logic             o_wake,          // One-cycle wake request on address match in sleep
  output logic             o_start_tx,      // One-cycle request to send START, bus now free
  output logic             o_flag           // Interrupt flag level
);

  // Synchronised pins and their previous values
  logic [1:0] pin_sync;
  logic       scl_s;
  logic       sda_s;
  logic       scl_q;
  logic       sda_q;

  // Control register bits
  logic       aa, start_request_col, stop_request_col, wc, en, ie;
  logic       next_flag, next_aa, next_sta, next_sto, next_wc, next_en, next_ie;
  logic [7:0] oar, next_oar;           // own_slave_address
  logic [7:0] dreg, next_dreg;         // serial_data_reg
  logic [7:0] code, next_code;         // Status code behind the flag

  // Serial engine state
  tws_state_t state, next_state;
  logic [3:0] cnt, next_cnt;           // Bits seen in the current byte
  logic [7:0] shreg, next_shreg;       // Shift register
  logic       tx_mode, next_tx_mode;   // Addressed for reading
  logic       gc_mode, next_gc_mode;   // Addressed by general call
  logic       arb_mode, next_arb_mode; // Addressed right after lost arbitration
  logic       last, next_last;         // Current transmit byte is the last one
  logic       ack_bit, next_ack_bit;   // Planned or received acknowledge
  logic       start_pend, next_start_pend;
  logic       busy, next_busy;         // Bus between START and STOP
  logic       next_scl_oe, next_sda_oe, next_wake, next_start_tx, next_wait;
  logic [31:0] next_readdata;

  // Decoded events
  logic scl_rise, scl_fall, start_c, stop_c;
  logic wr, rd_new, wr_ctrl, flag_clr, go, set_flag;
  logic own_hit, gc_hit, match, addressed_rx;

  tws_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async ({i_scl_in, i_sda_in}),
    .o_sync  (pin_sync)
  );

  assign scl_s = pin_sync[1];
  assign sda_s = pin_sync[0];

  // Line events; START and STOP need SCL high on both samples
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

  // Bus access decode: reads are sampled in the wait cycle, writes act when the wait drops
  assign wr       = i_write & ~o_waitrequest & i_byteenable[0];
  assign rd_new   = i_read & o_waitrequest;
  assign wr_ctrl  = wr && (i_address == TWS_OFS_CTRL);
  assign flag_clr = wr_ctrl & i_writedata[TWS_B_FLAG];
  assign go       = o_flag & flag_clr;

  // Address compare; no recognition at all while acknowledge is clear
  assign own_hit  = aa && (shreg[7:1] == oar[7:1]);
  assign gc_hit   = aa && oar[0] && (shreg[7:1] == TWS_GC_ADDR);
  assign match    = own_hit | gc_hit;
  assign addressed_rx = (state == TWS_RX) || (state == TWS_RX_ACK);

  // Next values of registers, bus answers and the serial engine
  always_comb
  begin
    next_aa = aa;
    next_sta = start_request_col;
    next_sto = stop_request_col;
    next_wc = wc;
    next_en = en;
    next_ie = ie;
    next_oar = oar;
    next_dreg = dreg;
    next_code = code;
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_tx_mode = tx_mode;
    next_gc_mode = gc_mode;
    next_arb_mode = arb_mode;
    next_last = last;
    next_ack_bit = ack_bit;
    next_start_pend = start_pend;
    next_busy = busy;
    next_sda_oe = o_sda_oe;
    next_wake = 1'b0;
    next_start_tx = 1'b0;
    set_flag = 1'b0;
    next_wait = ~((i_read | i_write) & o_waitrequest);
    next_readdata = o_readdata;

    // Register writes; unmapped offsets are ignored
    if (wr_ctrl)
    begin
      next_aa  = i_writedata[TWS_B_AA];
      next_sta = i_writedata[TWS_B_STA];
      next_sto = i_writedata[TWS_B_STO];
      next_en  = i_writedata[TWS_B_EN];
      next_ie  = i_writedata[TWS_B_IE];
    end
    else if (wr && (i_address == TWS_OFS_ADDR))
      next_oar = i_writedata[7:0];
    else if (wr && (i_address == TWS_OFS_DATA))
    begin
      // Writing while the engine owns the byte is a collision
      if (o_flag)
      begin
        next_dreg = i_writedata[7:0];
        next_wc   = 1'b0;
      end
      else
        next_wc = 1'b1;
    end

    // Read data captured in the wait cycle; unmapped offsets read zero
    if (rd_new)
    begin
      if (i_address == TWS_OFS_CTRL)
        next_readdata = {24'h00_0000, o_flag, aa, start_request_col, stop_request_col, wc, en, 1'b0, ie};
      else if (i_address == TWS_OFS_ADDR)
        next_readdata = {24'h00_0000, oar};
      else if (i_address == TWS_OFS_DATA)
        next_readdata = {24'h00_0000, dreg};
      else if (i_address == TWS_OFS_STAT)
        next_readdata = {24'h00_0000, o_flag ? code : TWS_ST_NOINFO};
      else
        next_readdata = 32'h0000_0000;
    end

    // Bus occupancy for the pending START
    if (start_c)
      next_busy = 1'b1;
    else if (stop_c)
      next_busy = 1'b0;

    // Serial engine; START/STOP take priority except while stretching SCL
    if (!en)
    begin
      next_state  = TWS_IDLE;
      next_sda_oe = 1'b0;
    end
    else if ((start_c || stop_c) && !(state == TWS_HOLD && code != TWS_ST_STOP))
    begin
      next_sda_oe = 1'b0;
      next_cnt    = 4'h0;
      next_state  = start_c ? TWS_ADDR : TWS_IDLE;
      if (addressed_rx)
      begin
        // No data register action on this event
        set_flag   = 1'b1;
        next_code  = TWS_ST_STOP;
        next_state = start_c ? TWS_ADDR : TWS_HOLD;
      end
    end
    else
    begin
      case (state)
        TWS_IDLE:
        begin
          // Not addressed: clocks are ignored, the master sees all ones
          next_sda_oe = 1'b0;
        end
        TWS_ADDR:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt   = cnt + 4'h1;
          end
          else if (scl_fall && cnt == TWS_BITS)
          begin
            if (match)
            begin
              next_sda_oe   = 1'b1;
              next_tx_mode  = shreg[0];
              next_gc_mode  = ~own_hit;
              next_arb_mode = i_arb_lost;
              next_wake     = i_deep_sleep;
              next_state    = TWS_ADDR_ACK;
            end
            else
              next_state = TWS_IDLE;
          end
        end
        TWS_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            set_flag    = 1'b1;
            next_state  = TWS_HOLD;
            if (tx_mode)
              next_code = arb_mode ? TWS_ST_ST_ARB : TWS_ST_ST_ADR;
            else if (gc_mode)
              next_code = arb_mode ? TWS_ST_GC_ARB : TWS_ST_GC_ADR;
            else
              next_code = arb_mode ? TWS_ST_SR_ARB : TWS_ST_SR_ADR;
          end
        end
        TWS_HOLD:
        begin
          // Wait for software to clear the flag; its new bits steer the next step
          if (go)
          begin
            next_cnt = 4'h0;
            if (code == TWS_ST_ST_ADR || code == TWS_ST_ST_ARB || code == TWS_ST_ST_ACK)
            begin
              next_sda_oe = ~dreg[7];
              next_shreg  = {dreg[6:0], 1'b0};
              next_last   = ~next_aa;
              next_state  = TWS_TX;
            end
            else if (code == TWS_ST_SR_NACK || code == TWS_ST_GC_NACK || code == TWS_ST_STOP
                     || code == TWS_ST_ST_NACK || code == TWS_ST_ST_LAST)
            begin
              next_state      = TWS_IDLE;
              next_start_pend = next_sta;
            end
            else
            begin
              next_ack_bit = next_aa;
              next_state   = TWS_RX;
            end
          end
        end
        TWS_RX:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt   = cnt + 4'h1;
          end
          else if (scl_fall && cnt == TWS_BITS)
          begin
            // In deep sleep the byte is not kept
            if (!i_deep_sleep)
              next_dreg = shreg;
            next_sda_oe = ack_bit;
            next_state  = TWS_RX_ACK;
          end
        end
        TWS_RX_ACK:
        begin
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            set_flag    = 1'b1;
            next_state  = TWS_HOLD;
            if (gc_mode)
              next_code = ack_bit ? TWS_ST_GC_ACK : TWS_ST_GC_NACK;
            else
              next_code = ack_bit ? TWS_ST_SR_ACK : TWS_ST_SR_NACK;
          end
        end
        TWS_TX:
        begin
          if (scl_rise)
            next_cnt = cnt + 4'h1;
          else if (scl_fall)
          begin
            if (cnt == TWS_BITS)
            begin
              next_sda_oe = 1'b0;
              next_state  = TWS_TX_ACK;
            end
            else
            begin
              next_sda_oe = ~shreg[7];
              next_shreg  = {shreg[6:0], 1'b0};
            end
          end
        end
        TWS_TX_ACK:
        begin
          if (scl_rise)
            next_ack_bit = ~sda_s;
          else if (scl_fall)
          begin
            set_flag   = 1'b1;
            next_state = TWS_HOLD;
            if (!ack_bit)
              next_code = TWS_ST_ST_NACK;
            else
              next_code = last ? TWS_ST_ST_LAST : TWS_ST_ST_ACK;
          end
        end
        default:
          next_state = TWS_IDLE;
      endcase
    end

    // Pending START goes out once the bus is free
    if (start_pend && !next_busy)
    begin
      next_start_tx   = 1'b1;
      next_start_pend = 1'b0;
    end

    // A hardware set in the same cycle as a software clear wins
    next_flag = set_flag | (o_flag & ~flag_clr);
    // Stretch SCL while software owns the transfer, also through wake-up
    next_scl_oe = (next_state == TWS_HOLD) && (next_code != TWS_ST_STOP);
  end

  // Register all state; control bits reset to a disabled interface
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      aa <= 1'b0; start_request_col <= 1'b0; stop_request_col <= 1'b0; wc <= 1'b0; en <= 1'b0; ie <= 1'b0;
      oar <= TWS_RST_ADDR;
      dreg <= TWS_RST_DATA;
      code <= TWS_ST_NOINFO;
      state <= TWS_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      tx_mode <= 1'b0; gc_mode <= 1'b0; arb_mode <= 1'b0; last <= 1'b0; ack_bit <= 1'b0;
      start_pend <= 1'b0; busy <= 1'b0;
      scl_q <= 1'b1; sda_q <= 1'b1;
      o_readdata <= 32'h0000_0000;
      o_waitrequest <= 1'b1;
      o_scl_out <= 1'b0; o_sda_out <= 1'b0;
      o_scl_oe <= 1'b0; o_sda_oe <= 1'b0;
      o_wake <= 1'b0; o_start_tx <= 1'b0; o_flag <= 1'b0;
    end
    else
    begin
      aa <= next_aa; start_request_col <= next_sta; stop_request_col <= next_sto; wc <= next_wc; en <= next_en; ie <= next_ie;
      oar <= next_oar;
      dreg <= next_dreg;
      code <= next_code;
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      tx_mode <= next_tx_mode; gc_mode <= next_gc_mode; arb_mode <= next_arb_mode;
      last <= next_last; ack_bit <= next_ack_bit;
      start_pend <= next_start_pend; busy <= next_busy;
      scl_q <= scl_s; sda_q <= sda_s;
      o_readdata <= next_readdata;
      o_waitrequest <= next_wait;
      o_scl_out <= 1'b0; o_sda_out <= 1'b0;
      o_scl_oe <= next_scl_oe; o_sda_oe <= next_sda_oe;
      o_wake <= next_wake; o_start_tx <= next_start_tx; o_flag <= next_flag;
    end
  end

  // Checks on the engine, all in the system clock domain
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_noinfo;
    (rd_new && i_address == TWS_OFS_STAT && !o_flag && !set_flag) |=> (o_readdata[7:0] == TWS_ST_NOINFO);
  endproperty
  a_noinfo: assert property (p_noinfo) else $error("status not no-information while flag clear");

  property p_gc_ack;
    (en && state == TWS_RX_ACK && gc_mode && ack_bit && scl_fall && !start_c && !stop_c)
      |=> (o_flag && code == TWS_ST_GC_ACK && o_scl_oe);
  endproperty
  a_gc_ack: assert property (p_gc_ack) else $error("general-call ack state wrong");

  property p_gc_nack_out;
    (state == TWS_HOLD && code == TWS_ST_GC_NACK && go && en) |=> (state == TWS_IDLE && !o_flag) ##1 !o_scl_oe;
  endproperty
  a_gc_nack_out: assert property (p_gc_nack_out) else $error("no return to unaddressed after nack");

  property p_start_req;
    (state == TWS_HOLD && go && en && next_sta && next_state == TWS_IDLE) |=> ##[0:1] (start_pend || o_start_tx);
  endproperty
  a_start_req: assert property (p_start_req) else $error("start request lost");

  property p_stop_addr;
    (en && stop_c && addressed_rx) |=> (o_flag && code == TWS_ST_STOP && state == TWS_HOLD && !o_scl_oe);
  endproperty
  a_stop_addr: assert property (p_stop_addr) else $error("stop while addressed not reported");

  property p_isolate;
    (en && state == TWS_ADDR && cnt == TWS_BITS && scl_fall && !aa && !start_c && !stop_c)
      |=> (state == TWS_IDLE && !o_sda_oe);
  endproperty
  a_isolate: assert property (p_isolate) else $error("address answered with acknowledge clear");

  property p_dir;
    (en && state == TWS_ADDR && cnt == TWS_BITS && scl_fall && match && !start_c && !stop_c)
      |=> (tx_mode == $past(shreg[0]) && o_sda_oe && state == TWS_ADDR_ACK);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit not followed");

  property p_last;
    (en && state == TWS_TX_ACK && last && ack_bit && scl_fall && !start_c && !stop_c)
      |=> (code == TWS_ST_ST_LAST && o_flag);
  endproperty
  a_last: assert property (p_last) else $error("last byte acked not reported");

  property p_hold;
    (state == TWS_HOLD && code != TWS_ST_STOP) |-> o_scl_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("SCL released before flag clear");

  c_tx_ack: cover property (state == TWS_TX_ACK ##[1:200] code == TWS_ST_ST_ACK);
  c_gc_rx: cover property (code == TWS_ST_GC_ACK && o_flag);
  c_wake: cover property (o_wake ##[1:1000] go);

endmodule

// ===== verification/tws_mstr.sv
// Bus master model for the two-wire slave bench.
// Assumes pull-ups: the bench ANDs these releases with the slave's pull-downs.
`timescale 1ns/1ns
module tws_mstr (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // Both lines released outside frames
  initial
  begin
    o_scl = 1;
    o_sda = 1;
  end
  // One bit in a 125 ns period; waits while the slave stretches SCL
  task automatic xb(input logic b, output logic s);
    o_sda = b;
    #31 o_scl = 1;
    wait (i_scl);
    #31 s = i_sda;
    #32 o_scl = 0;
    #31;
  endtask
  // START, also usable as a repeated START
  task automatic start_c();
    o_sda = 1;
    #31 o_scl = 1;
    wait (i_scl);
    #62 o_sda = 0;
    #62 o_scl = 0;
    #31;
  endtask
  task automatic stop_c();
    o_sda = 0;
    #31 o_scl = 1;
    wait (i_scl);
    #62 o_sda = 1;
    #62;
  endtask
  // MSB first, SDA released for the ack bit
  task automatic send8(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      xb(d[i], s);
    o_sda = 1;
  endtask
  task automatic rd8(output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      xb(1'b1, d[i]);
  endtask
endmodule

// ===== verification/tb.sv
// Bench for the two-wire slave: Avalon register traffic plus a bus master model.
// Assumes open-drain lines with pull-ups, modelled as a wired AND.
`timescale 1ns/1ns
module tb;
  import tws_pkg::*;
  logic        i_mclk, i_rst_n, i_read, i_write, i_arb_lost, i_deep_sleep;
  logic [4:0]  i_address;
  logic [31:0] i_writedata, o_readdata;
  logic [3:0]  i_byteenable;
  logic        o_waitrequest, o_scl_out, o_scl_oe, o_sda_out, o_sda_oe;
  logic        o_wake, o_start_tx, o_flag, m_scl, m_sda, s, saw_wake, saw_sta;
  logic [7:0]  q, b;
  int          num_errors, n_compared, cyc;
  wire         scl = m_scl & (o_scl_oe ? o_scl_out : 1'b1);
  wire         sda = m_sda & (o_sda_oe ? o_sda_out : 1'b1);
  tws_slave DUT (.i_mclk, .i_rst_n, .i_address, .i_read, .i_write, .i_writedata, .i_byteenable,
    .o_readdata, .o_waitrequest, .i_scl_in(scl), .o_scl_out, .o_scl_oe, .i_sda_in(sda),
    .o_sda_out, .o_sda_oe, .i_arb_lost, .i_deep_sleep, .o_wake, .o_start_tx, .o_flag);
  tws_mstr M (.i_scl(scl), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
  initial
  begin
    i_mclk = 0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Pulses are one cycle wide, so keep a sticky copy; also cut hangs short
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (o_wake === 1'b1) saw_wake <= 1;
    if (o_start_tx === 1'b1) saw_sta <= 1;
    if (cyc == 40000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_address <= a;
    i_writedata <= {24'h00_0000, d};
    i_write <= w;
    i_read <= !w;
    do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
    q = o_readdata[7:0];
    i_write <= 0;
    i_read <= 0;
  endtask
  task automatic st(input logic [7:0] e);
    bus(0, TWS_OFS_STAT, 8'h00);
    chk("status", e, q & 8'hF8);
  endtask
  task automatic wflag();
    for (int n = 0; n < 3000 && o_flag !== 1'b1; n++)
      @(posedge i_mclk);
  endtask
  task automatic t_tx();
    bus(1, TWS_OFS_ADDR, 8'h55);
    bus(1, TWS_OFS_CTRL, 8'h44);
    M.start_c();
    M.send8(8'h55);
    M.xb(1'b1, s);
    chk("addr ack", 8'h00, {7'h00, s});
    wflag();
    st(TWS_ST_ST_ADR);
    bus(1, TWS_OFS_DATA, 8'hA5);
    bus(1, TWS_OFS_CTRL, 8'hC4);
    M.rd8(b);
    chk("byte", 8'hA5, b);
    M.xb(1'b0, s);
    wflag();
    st(TWS_ST_ST_ACK);
    bus(1, TWS_OFS_DATA, 8'h3C);
    bus(1, TWS_OFS_CTRL, 8'h84);
    M.rd8(b);
    chk("last", 8'h3C, b);
    M.xb(1'b0, s);
    wflag();
    st(TWS_ST_ST_LAST);
    bus(1, TWS_OFS_CTRL, 8'hC4);
    M.rd8(b);
    chk("released", 8'hFF, b);
    M.xb(1'b1, s);
    M.stop_c();
    st(TWS_ST_NOINFO);
  endtask
  task automatic t_gc();
    M.start_c();
    M.send8(8'h00);
    M.xb(1'b1, s);
    chk("gc addr ack", 8'h00, {7'h00, s});
    wflag();
    st(TWS_ST_GC_ADR);
    bus(1, TWS_OFS_CTRL, 8'hC4);
    M.send8(8'h12);
    M.xb(1'b1, s);
    chk("gc ack", 8'h00, {7'h00, s});
    wflag();
    st(TWS_ST_GC_ACK);
    bus(0, TWS_OFS_DATA, 8'h00);
    chk("gc data", 8'h12, q);
    bus(1, TWS_OFS_CTRL, 8'h84);
    M.send8(8'h34);
    M.xb(1'b1, s);
    chk("gc nack", 8'h01, {7'h00, s});
    wflag();
    st(TWS_ST_GC_NACK);
    bus(1, TWS_OFS_CTRL, 8'hE4);
    M.stop_c();
    for (int n = 0; n < 500 && !saw_sta; n++)
      @(posedge i_mclk);
    chk("start", 8'h01, {7'h00, saw_sta});
    bus(1, TWS_OFS_CTRL, 8'h44);
  endtask
  task automatic t_iso();
    // A write without byte lane 0 is dropped; a data write with the flag clear collides
    i_byteenable <= 4'h0;
    bus(1, TWS_OFS_ADDR, 8'h12);
    i_byteenable <= 4'h1;
    bus(1, TWS_OFS_DATA, 8'h77);
    bus(0, TWS_OFS_ADDR, 8'h00);
    chk("byteenable", 8'h55, q);
    bus(0, TWS_OFS_CTRL, 8'h00);
    chk("collision", 8'h4C, q);
    bus(1, TWS_OFS_CTRL, 8'h04);
    M.start_c();
    M.send8(8'h55);
    M.xb(1'b1, s);
    chk("isolated", 8'h01, {7'h00, s});
    M.stop_c();
    bus(1, TWS_OFS_CTRL, 8'h44);
    i_deep_sleep <= 1;
    i_arb_lost <= 1;
    M.start_c();
    M.send8(8'h55);
    M.xb(1'b1, s);
    chk("sleep ack", 8'h00, {7'h00, s});
    wflag();
    st(TWS_ST_ST_ARB);
    chk("wake", 8'h01, {7'h00, saw_wake});
    chk("scl held", 8'h01, {7'h00, o_scl_oe});
    i_deep_sleep <= 0;
    i_arb_lost <= 0;
    bus(1, TWS_OFS_DATA, 8'h5A);
    bus(1, TWS_OFS_CTRL, 8'h84);
    M.rd8(b);
    chk("arb byte", 8'h5A, b);
    M.xb(1'b1, s);
    wflag();
    st(TWS_ST_ST_NACK);
    bus(1, TWS_OFS_CTRL, 8'hC4);
    M.stop_c();
    M.start_c();
    M.send8(8'h54);
    M.xb(1'b1, s);
    wflag();
    st(TWS_ST_SR_ADR);
    bus(1, TWS_OFS_CTRL, 8'hC4);
    M.stop_c();
    wflag();
    st(TWS_ST_STOP);
  endtask
  initial
  begin
    i_rst_n = 0;
    {i_read, i_write, i_arb_lost, i_deep_sleep, saw_wake, saw_sta} = 6'h00;
    i_address = 5'h00;
    i_writedata = 32'h0000_0000;
    i_byteenable = 4'h1;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1;
    st(TWS_ST_NOINFO);
    t_tx();
    t_gc();
    t_iso();
    wrap_up();
  end
endmodule
